/* File: logic/pdwc_pkg.sv */
package pdwc_pkg;

  // ********************************************************************
  // Device destination codes on the two select pins.
  // ********************************************************************
  localparam logic [1:0] DEST_LOW  = 2'h0;
  localparam logic [1:0] DEST_HIGH = 2'h1;
  localparam logic [1:0] DEST_RSVD = 2'h2;
  localparam logic [1:0] DEST_CTRL = 2'h3;

  // ********************************************************************
  // Device control byte fields.
  // ********************************************************************
  localparam int CTL_SPEED_BIT = 0;
  localparam int CTL_POWER_BIT = 1;
  localparam int CTL_LOAD_BIT  = 2;

  // ********************************************************************
  // Controller registers on the Wishbone side (byte addresses).
  // ********************************************************************
  localparam logic [3:0] REG_CODE   = 4'h0;
  localparam logic [3:0] REG_MODE   = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_RAW    = 4'hC;

  localparam int MODE_SPEED_BIT = 0;
  localparam int MODE_POWER_BIT = 1;
  localparam int MODE_PIN_SPEED = 2;
  localparam int MODE_PIN_PWR_N = 3;
  localparam int MODE_PIN_LD_N  = 4;

  localparam int RAW_DEST_LSB = 8;
  localparam int RAW_GO_BIT   = 16;

  // ********************************************************************
  // Strobe timing at 200 MHz.
  // ********************************************************************
  localparam int CLK_PERIOD_NS   = 5;
  localparam int SETUP_NS        = 17;
  localparam int STROBE_HIGH_NS  = 10;
  localparam int SETUP_CYC       = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIGH_CYC        = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SETUP_CNT = 4'(SETUP_CYC);
  localparam logic [3:0] HIGH_CNT  = 4'(HIGH_CYC);

  typedef enum {
    PDWC_IDLE,
    PDWC_SETUP,
    PDWC_RISE,
    PDWC_GAP
  } pdwc_state_t;

  // Pins driven toward the converter.
  typedef struct packed {
    logic       chip_sel_n;
    logic       write_n;
    logic [1:0] dest;
    logic [7:0] data;
    logic       speed_select;
    logic       power_down_n;
    logic       load_strobe_n;
  } pdwc_pins_t;

endpackage

/* File: logic/pdwc_ctrl.sv */
// The implementer's own choice: the Wishbone interface to the registers.
module pdwc_ctrl (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic                   wb_ack_o,
  output pdwc_pkg::pdwc_pins_t   pins
);

  // ********************************************************************
  // State.
  // ********************************************************************
  typedef struct packed {
    pdwc_pkg::pdwc_state_t st;
    logic [3:0]            cnt;
    logic [1:0]            step;
    logic                  seq;
    logic [11:0]           code;
    logic [7:0]            raw_data;
    logic [1:0]            raw_dest;
    logic [4:0]            mode;
    logic [1:0]            cur_dest;
    logic [7:0]            cur_data;
    logic [11:0]           last_code;
    logic [31:0]           rdata;
    logic                  ack;
    logic                  strobe;
  } pdwc_reg_t;

  pdwc_reg_t s_r;
  pdwc_reg_t s_nxt;

  function automatic logic [7:0] ctl_byte(input logic speed, input logic power,
                                          input logic load);
    logic [7:0] b;
    b = 8'h00;
    b[pdwc_pkg::CTL_SPEED_BIT] = speed;
    b[pdwc_pkg::CTL_POWER_BIT] = power;
    b[pdwc_pkg::CTL_LOAD_BIT]  = load;
    return b;
  endfunction

  logic busy;
  logic wr_req;
  // Writes that arrive while a byte is on the pins are acked but dropped, so software
  // polls the busy flag; queueing them would need a buffer that nothing asks for.
  assign busy   = (s_r.st != pdwc_pkg::PDWC_IDLE);
  assign wr_req = wb_cyc_i && wb_stb_i && !s_r.ack;

  // ********************************************************************
  // Next state.
  // ********************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    if (wr_req) begin
      s_nxt.ack = 1'b1;
      if (wb_we_i && !busy && wb_sel_i[0]) begin
        if (wb_adr_i == pdwc_pkg::REG_CODE) begin
          s_nxt.code = wb_dat_i[11:0];
          s_nxt.seq  = 1'b1;
          s_nxt.step = 2'h0;
          s_nxt.st   = pdwc_pkg::PDWC_SETUP;
          s_nxt.cnt  = 4'h0;
        end else if (wb_adr_i == pdwc_pkg::REG_MODE) begin
          s_nxt.mode = wb_dat_i[4:0];
        end else if (wb_adr_i == pdwc_pkg::REG_RAW && wb_dat_i[pdwc_pkg::RAW_GO_BIT]) begin
          s_nxt.raw_data = wb_dat_i[7:0];
          s_nxt.raw_dest = wb_dat_i[pdwc_pkg::RAW_DEST_LSB +: 2];
          s_nxt.seq      = 1'b0;
          s_nxt.st       = pdwc_pkg::PDWC_SETUP;
          s_nxt.cnt      = 4'h0;
        end
      end
      if (wb_adr_i == pdwc_pkg::REG_CODE) begin
        s_nxt.rdata = {20'h00000, s_r.code};
      end else if (wb_adr_i == pdwc_pkg::REG_MODE) begin
        s_nxt.rdata = {27'h0000000, s_r.mode};
      end else if (wb_adr_i == pdwc_pkg::REG_STATUS) begin
        s_nxt.rdata = {19'h00000, s_r.last_code, busy};
      end else begin
        s_nxt.rdata = 32'h00000000;
      end
    end
    case (s_r.st)
      pdwc_pkg::PDWC_IDLE: begin
      end
      pdwc_pkg::PDWC_SETUP: begin
        s_nxt.cnt = s_r.cnt + 4'h1;
        if (s_r.cnt == pdwc_pkg::SETUP_CNT) begin
          s_nxt.st = pdwc_pkg::PDWC_RISE;
        end
      end
      pdwc_pkg::PDWC_RISE: begin
        s_nxt.st  = pdwc_pkg::PDWC_GAP;
        s_nxt.cnt = 4'h0;
      end
      default: begin
        s_nxt.cnt = s_r.cnt + 4'h1;
        if (s_r.cnt == pdwc_pkg::HIGH_CNT) begin
          s_nxt.cnt = 4'h0;
          if (s_r.seq && s_r.step != 2'h3) begin
            s_nxt.step = s_r.step + 2'h1;
            s_nxt.st   = pdwc_pkg::PDWC_SETUP;
          end else begin
            if (s_r.seq) begin
              s_nxt.last_code = s_r.code;
            end
            s_nxt.seq = 1'b0;
            s_nxt.st  = pdwc_pkg::PDWC_IDLE;
          end
        end
      end
    endcase
    // Sequence: clear soft load, high byte, low byte, set soft load.
    // The byte follows the step being entered, so destination and data are settled
    // in the first cycle of the strobe; a one-cycle lag would show the previous
    // destination at the converter while the strobe is already low.
    if (s_nxt.seq) begin
      case (s_nxt.step)
        2'h0: begin
          s_nxt.cur_dest = pdwc_pkg::DEST_CTRL;
          s_nxt.cur_data = ctl_byte(s_nxt.mode[pdwc_pkg::MODE_SPEED_BIT],
                                    s_nxt.mode[pdwc_pkg::MODE_POWER_BIT], 1'b0);
        end
        2'h1: begin
          s_nxt.cur_dest = pdwc_pkg::DEST_HIGH;
          s_nxt.cur_data = {4'h0, s_nxt.code[11:8]};
        end
        2'h2: begin
          s_nxt.cur_dest = pdwc_pkg::DEST_LOW;
          s_nxt.cur_data = s_nxt.code[7:0];
        end
        default: begin
          s_nxt.cur_dest = pdwc_pkg::DEST_CTRL;
          s_nxt.cur_data = ctl_byte(s_nxt.mode[pdwc_pkg::MODE_SPEED_BIT],
                                    s_nxt.mode[pdwc_pkg::MODE_POWER_BIT], 1'b1);
        end
      endcase
    end else begin
      s_nxt.cur_dest = s_nxt.raw_dest;
      s_nxt.cur_data = s_nxt.raw_data;
    end
    // The strobe is a flop so that the capture edge on the pins cannot glitch.
    s_nxt.strobe = (s_nxt.st == pdwc_pkg::PDWC_SETUP);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ********************************************************************
  // Outputs.
  // ********************************************************************
  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.rdata;

  always_comb begin
    pins.chip_sel_n    = !s_r.strobe;
    pins.write_n       = !s_r.strobe;
    pins.dest          = s_r.cur_dest;
    pins.data          = s_r.cur_data;
    pins.speed_select  = s_r.mode[pdwc_pkg::MODE_PIN_SPEED];
    pins.power_down_n  = !s_r.mode[pdwc_pkg::MODE_PIN_PWR_N];
    pins.load_strobe_n = !s_r.mode[pdwc_pkg::MODE_PIN_LD_N];
  end

  a_strobe_rise: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == pdwc_pkg::PDWC_SETUP) ##1 (s_r.st == pdwc_pkg::PDWC_RISE)
      |-> pins.write_n && $past(!pins.chip_sel_n))
    else $error("write strobe rose without chip select");
  a_no_reserved: assert property (@(posedge clk) disable iff (rst)
    s_r.seq && !pins.write_n |-> pins.dest != pdwc_pkg::DEST_RSVD)
    else $error("sequence used reserved destination");
  a_high_nibble: assert property (@(posedge clk) disable iff (rst)
    s_r.seq && !pins.write_n && pins.dest == pdwc_pkg::DEST_HIGH |-> pins.data[7:4] == 4'h0)
    else $error("upper nibble not zero");
  a_load_last: assert property (@(posedge clk) disable iff (rst)
    s_r.seq && s_r.step == 2'h3 && !pins.write_n |-> pins.data[pdwc_pkg::CTL_LOAD_BIT])
    else $error("final control byte lacks load");
  a_load_first: assert property (@(posedge clk) disable iff (rst)
    s_r.seq && s_r.step == 2'h0 && !pins.write_n |-> !pins.data[pdwc_pkg::CTL_LOAD_BIT])
    else $error("first control byte sets load");
  a_ack_pulse: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_data_stable: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == pdwc_pkg::PDWC_RISE) |-> $stable(pins.data) && $stable(pins.dest))
    else $error("data changed at strobe edge");
  a_ctrl_upper: assert property (@(posedge clk) disable iff (rst)
    s_r.seq && pins.dest == pdwc_pkg::DEST_CTRL && !pins.write_n |-> pins.data[7:3] == 5'h00)
    else $error("control byte upper bits set");

endmodule // pdwc_ctrl

/* File: dv/pdwc_dev_model.sv */
// Converter side: holding latches, control bits and the output latch.
module pdwc_dev_model (
  input  pdwc_pkg::pdwc_pins_t pins,
  output logic [11:0]          dac_out,
  output logic [2:0]           ctl_r,
  output logic                 fast,
  output logic                 pwr_dn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lo_r = 8'h00;
  logic [3:0] hi_r = 4'h0;
  logic       sel_q = 1'b0;
  logic       transp;
  initial ctl_r = 3'h0;
  initial dac_out = 12'h000;
  // Select may rise in the same step as the strobe, so its level before that step is used.
  always @(pins.chip_sel_n) sel_q <= ~pins.chip_sel_n;
  always @(posedge pins.write_n) begin
    if (sel_q) begin
      case (pins.dest)
        pdwc_pkg::DEST_LOW:  lo_r = pins.data;
        pdwc_pkg::DEST_HIGH: hi_r = pins.data[3:0];
        pdwc_pkg::DEST_CTRL: ctl_r = pins.data[2:0];
        default: ;
      endcase
    end
  end
  assign transp = ~pins.load_strobe_n | ctl_r[pdwc_pkg::CTL_LOAD_BIT];
  always @* if (transp) dac_out = {hi_r, lo_r};
  assign fast = pins.speed_select | ctl_r[pdwc_pkg::CTL_SPEED_BIT];
  assign pwr_dn = ~(pins.power_down_n & ~ctl_r[pdwc_pkg::CTL_POWER_BIT]);
endmodule // pdwc_dev_model

/* File: dv/tb_pdwc_ctrl.sv */
module tb_pdwc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic [3:0]           wb_adr = 4'h0;
  logic [31:0]          wb_dat = 32'h0;
  logic                 wb_we = 1'b0;
  logic [3:0]           wb_sel = 4'h0;
  logic                 wb_cyc = 1'b0;
  logic                 wb_stb = 1'b0;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;
  pdwc_pkg::pdwc_pins_t pins;
  logic [11:0]          dac_out;
  logic [2:0]           ctl_r;
  logic                 fast;
  logic                 pwr_dn;
  logic [31:0]          q;
  int                   n_errors = 0;
  int                   total_checks = 0;

  pdwc_ctrl i_pdwc_ctrl (.clk(clk), .rst(rst), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_ack_o(wb_ack_o), .pins(pins));
  pdwc_dev_model i_pdwc_dev_model (.pins(pins), .dac_out(dac_out), .ctl_r(ctl_r),
    .fast(fast), .pwr_dn(pwr_dn));

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 4'hF;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_sel <= 4'h0;
    if (n >= 40) chk("ack", 32'h1, 32'h0);
  endtask

  task automatic idle();
    int n;
    n = 0;
    do begin
      wb(1'b0, pdwc_pkg::REG_STATUS, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 100);
    chk("busy", 32'h0, {31'h0, q[0]});
  endtask

  task automatic raw(input logic [1:0] dst, input logic [7:0] b);
    wb(1'b1, pdwc_pkg::REG_RAW, {15'h0, 1'b1, 6'h0, dst, b});
    idle();
  endtask

  task automatic mode(input logic [4:0] v);
    wb(1'b1, pdwc_pkg::REG_MODE, {27'h0, v});
    wb(1'b0, pdwc_pkg::REG_MODE, 32'h0);
    chk("mode", {27'h0, v}, q);
  endtask

  task automatic t_reset();
    chk("strobes", 32'h3, {30'h0, pins.chip_sel_n, pins.write_n});
    chk("dac", 32'h0, {20'h0, dac_out});
    chk("modes", 32'h0, {27'h0, ctl_r, fast, pwr_dn});
  endtask

  task automatic t_code();
    wb(1'b1, pdwc_pkg::REG_CODE, 32'hA5C);
    idle();
    chk("dac", 32'hA5C, {20'h0, dac_out});
    wb(1'b1, pdwc_pkg::REG_CODE, 32'h3F0);
    wb(1'b1, pdwc_pkg::REG_CODE, 32'h111);
    idle();
    chk("last", 32'h3F0, {20'h0, q[12:1]});
    chk("dac", 32'h3F0, {20'h0, dac_out});
    chk("load", 32'h1, {31'h0, ctl_r[2]});
  endtask

  task automatic t_raw();
    raw(2'h1, 8'hF7);
    chk("dac", 32'h7F0, {20'h0, dac_out});
    raw(2'h2, 8'hFF);
    chk("dac", 32'h7F0, {20'h0, dac_out});
    chk("ctl", 32'h4, {29'h0, ctl_r});
    raw(2'h3, 8'hF8);
    raw(2'h0, 8'h12);
    chk("hold", 32'h7F0, {20'h0, dac_out});
    mode(5'h10);
    chk("pin load", 32'h712, {20'h0, dac_out});
    mode(5'h00);
    raw(2'h3, 8'hF9);
    chk("fast", 32'h2, {30'h0, fast, pwr_dn});
    raw(2'h3, 8'hFA);
    chk("down", 32'h1, {30'h0, fast, pwr_dn});
    raw(2'h3, 8'hF8);
    mode(5'h04);
    chk("speed pin", 32'h2, {30'h0, fast, pwr_dn});
    mode(5'h08);
    chk("pwr pin", 32'h1, {30'h0, fast, pwr_dn});
    mode(5'h03);
    wb(1'b1, pdwc_pkg::REG_CODE, 32'h0FF);
    idle();
    chk("ctl", 32'h7, {29'h0, ctl_r});
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask

  task automatic t_rerun();
    mode(5'h1C);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk("load pin", 32'h1, {31'h0, pins.load_strobe_n});
    chk("power pin", 32'h1, {31'h0, pins.power_down_n});
    chk("strobes", 32'h3, {30'h0, pins.chip_sel_n, pins.write_n});
    wb(1'b0, pdwc_pkg::REG_MODE, 32'h0);
    chk("mode", 32'h0, q);
  endtask

  task automatic complete_run();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_code();
    t_raw();
    t_rerun();
    complete_run();
  end
endmodule // tb_pdwc_ctrl
